/* src/jesd_tl_pkg.sv */
package jesd_tl_pkg;

    // geometry
    localparam int LANES      = 8;
    localparam int CHANNELS   = 4;
    localparam int SLOT_W     = 12;
    localparam int FRAME_W    = 64;
    localparam int OCTET_W    = 8;
    localparam int MAX_SPC    = 10;
    localparam int PAIR_W     = 2 * SLOT_W;
    localparam int WORD_W     = CHANNELS * PAIR_W;
    localparam int FIFO_DEPTH = 32;
    localparam int LANE_ID_W  = 3;

    // link modes handled by the mapper
    localparam logic [3:0] MODE_12B_8L = 4'h0;
    localparam logic [3:0] MODE_12B_6L = 4'h1;
    localparam logic [3:0] MODE_8B_4L  = 4'h2;
    localparam logic [3:0] MODE_10B_4L = 4'h3;
    // 64b/66b modes, only their derived multiframe length is reported
    localparam logic [3:0] MODE_W4     = 4'h4;
    localparam logic [3:0] MODE_W5     = 4'h5;
    localparam logic [3:0] MODE_W6     = 4'h6;
    localparam logic [3:0] MODE_W7     = 4'h7;
    localparam logic [3:0] MODE_W8     = 4'h8;
    localparam logic [3:0] MODE_W14    = 4'he;
    localparam logic [3:0] MODE_W15    = 4'hf;

    // transport parameters per mode: lanes, converters, octets, samples, resolution
    localparam logic [3:0] L_M0 = 4'h8, M_M0 = 4'h8, F_M0 = 4'h8, S_M0 = 4'h5, N_M0 = 4'hc;
    localparam logic [3:0] L_M1 = 4'h6, M_M1 = 4'h4, F_M1 = 4'h2, S_M1 = 4'h2, N_M1 = 4'hc;
    localparam logic [3:0] L_M2 = 4'h4, M_M2 = 4'h4, F_M2 = 4'h1, S_M2 = 4'h1, N_M2 = 4'h8;
    localparam logic [3:0] L_M3 = 4'h4, M_M3 = 4'h4, F_M3 = 4'h5, S_M3 = 4'h4, N_M3 = 4'ha;

    // input words (two samples per channel) gathered per frame, per two frames in mode 2
    localparam logic [2:0] WPF_M0 = 3'h5;
    localparam logic [2:0] WPF_M1 = 3'h1;
    localparam logic [2:0] WPF_M2 = 3'h1;
    localparam logic [2:0] WPF_M3 = 3'h2;

    // multiframe length limits for 8b/10b modes
    localparam logic [8:0] K_MIN_M0  = 9'h004;
    localparam logic [8:0] K_MIN_M1  = 9'h010;
    localparam logic [8:0] K_MIN_M23 = 9'h020;
    localparam logic [8:0] K_MAX     = 9'h100;

    // 64b/66b: K = K_MUL_A * K_MUL_B * E / F
    localparam int K_MUL_A = 8;
    localparam int K_MUL_B = 32;
    localparam int E_W4 = 1, F_W4 = 2;
    localparam int E_W5 = 1, F_W5 = 2;
    localparam int E_W6 = 1, F_W6 = 2;
    localparam int E_W7 = 1, F_W7 = 1;
    localparam int E_W8 = 3, F_W8 = 3;
    localparam int E_W14 = 3, F_W14 = 3;
    localparam int E_W15 = 3, F_W15 = 3;

endpackage : jesd_tl_pkg

/* src/jesd_transport_lane_mapper.sv */
// Functional notes
// - Lane packing follows the transport parameters of the selected link mode.
// - Flagged modes report converter count equal to lane count.
// - In 64b/66b modes K is derived as 8*32*E/F, not programmed.
// - Eight serial lanes, numbered 0 to 7, carry link data.
// - Lowest lanes are used; higher lanes are powered down automatically.
// - Lane identifier equals lane number; device identifier is shared by all lanes.
// - Every tail bit inserted in a frame is zero.
// - Samples go out most significant bit first.
// - Sample slots identify channel and in-frame index; lower index is earlier.
// - Mode 0: five 12-bit samples plus 4-bit zero tail, even/odd lane pairs.
// - Mode 1: six lanes of 16-bit frames splitting sample pairs across lanes.
// - Mode 2: four lanes, one 8-bit sample each, channels A to D.
// - Mode 3: four lanes, five octets holding four 10-bit samples each.
// - In 8b/10b modes K comes from K-minus-one, held to min, step, max.
// - Mode 0 is 12-bit, eight lanes, eight octets, five samples per converter.
`timescale 1ns/1ps

module sample_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             full_reg;
    logic             empty_reg;
    logic             push;
    logic             pop;

    assign push       = in_valid && !full_reg;
    assign pop        = out_ready && !empty_reg;
    assign out_valid  = !empty_reg;
    assign out_data   = mem[rd_ptr_reg];
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
            end
        end
    end

    // flags registered so the ready seen outside comes from a flop
    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= '0;
            full_reg  <= 1'b0;
            in_ready  <= 1'b1;
            empty_reg <= 1'b1;
        end else begin
            count_reg <= count_next;
            full_reg  <= (count_next == (AW+1)'(DEPTH));
            in_ready  <= (count_next != (AW+1)'(DEPTH));
            empty_reg <= (count_next == '0);
        end
    end

endmodule : sample_fifo

module jesd_transport_lane_mapper #(
    parameter int FIFO_WORDS = jesd_tl_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    // configuration
    input  wire logic [3:0]                             link_mode_select,
    input  wire logic [7:0]                             frames_per_multiframe_minus_one,
    input  wire logic [7:0]                             device_id,
    input  wire logic                                   data_phase,
    // sample input, two samples per channel per word
    input  wire logic [jesd_tl_pkg::WORD_W-1:0]         sample_data,
    input  wire logic                                   sample_valid,
    output logic                                        sample_ready,
    // lane octets, lane i in bits [8i+7:8i]
    output logic [jesd_tl_pkg::LANES*8-1:0]             lane_data,
    output logic                                        lane_valid,
    output logic                                        frame_start,
    output logic [jesd_tl_pkg::LANES-1:0]               lane_power_down,
    output logic [jesd_tl_pkg::LANES*3-1:0]             lane_id,
    output logic [7:0]                                  lane_device_id,
    // reported link parameters
    output logic [3:0]                                  param_l,
    output logic [3:0]                                  param_m,
    output logic [3:0]                                  param_f,
    output logic [3:0]                                  param_s,
    output logic [3:0]                                  param_n,
    output logic [8:0]                                  param_k,
    output logic                                        mode_unsupported
);
    localparam int LN = jesd_tl_pkg::LANES;
    localparam int CH = jesd_tl_pkg::CHANNELS;
    localparam int SW = jesd_tl_pkg::SLOT_W;
    localparam int FW = jesd_tl_pkg::FRAME_W;
    localparam int OW = jesd_tl_pkg::OCTET_W;

    logic [jesd_tl_pkg::WORD_W-1:0] fifo_data;
    logic                           fifo_valid;
    logic                           fifo_pop;

    logic [SW-1:0] samp [CH][jesd_tl_pkg::MAX_SPC];
    logic [2:0]    gcnt_reg;
    logic          gathered_reg;
    logic          half_reg;
    logic          active_reg;
    logic [3:0]    ocnt_reg;
    logic [FW-1:0] shreg [LN];
    logic [FW-1:0] frame_map [LN];

    logic          mode_ok;
    logic [3:0]    l_cnt, m_cnt, f_oct, s_cnt, n_bits;
    logic [2:0]    words_pf;
    logic [8:0]    k_val;
    logic          last_octet;
    logic          load;
    logic          last_use;
    logic          complete;

    sample_fifo #(
        .WIDTH (jesd_tl_pkg::WORD_W),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_comb begin
        mode_ok  = 1'b1;
        l_cnt    = 4'h0;
        m_cnt    = 4'h0;
        f_oct    = 4'h1;
        s_cnt    = 4'h0;
        n_bits   = 4'h0;
        words_pf = 3'h1;
        case (link_mode_select)
            jesd_tl_pkg::MODE_12B_8L: begin
                l_cnt = jesd_tl_pkg::L_M0; m_cnt = jesd_tl_pkg::M_M0; f_oct = jesd_tl_pkg::F_M0;
                s_cnt = jesd_tl_pkg::S_M0; n_bits = jesd_tl_pkg::N_M0; words_pf = jesd_tl_pkg::WPF_M0;
            end
            jesd_tl_pkg::MODE_12B_6L: begin
                l_cnt = jesd_tl_pkg::L_M1; m_cnt = jesd_tl_pkg::M_M1; f_oct = jesd_tl_pkg::F_M1;
                s_cnt = jesd_tl_pkg::S_M1; n_bits = jesd_tl_pkg::N_M1; words_pf = jesd_tl_pkg::WPF_M1;
            end
            jesd_tl_pkg::MODE_8B_4L: begin
                l_cnt = jesd_tl_pkg::L_M2; m_cnt = jesd_tl_pkg::M_M2; f_oct = jesd_tl_pkg::F_M2;
                s_cnt = jesd_tl_pkg::S_M2; n_bits = jesd_tl_pkg::N_M2; words_pf = jesd_tl_pkg::WPF_M2;
            end
            jesd_tl_pkg::MODE_10B_4L: begin
                l_cnt = jesd_tl_pkg::L_M3; m_cnt = jesd_tl_pkg::M_M3; f_oct = jesd_tl_pkg::F_M3;
                s_cnt = jesd_tl_pkg::S_M3; n_bits = jesd_tl_pkg::N_M3; words_pf = jesd_tl_pkg::WPF_M3;
            end
            default: begin
                mode_ok = 1'b0;
            end
        endcase
    end

    // multiframe length
    always_comb begin
        k_val = {1'b0, frames_per_multiframe_minus_one} + 9'h001;
        case (link_mode_select)
            // round down to the step, hold at the minimum
            jesd_tl_pkg::MODE_12B_8L: k_val = (k_val & ~(jesd_tl_pkg::K_MIN_M0 - 9'h001)) | 9'h000;
            jesd_tl_pkg::MODE_12B_6L: k_val = k_val & ~(jesd_tl_pkg::K_MIN_M1 - 9'h001);
            jesd_tl_pkg::MODE_8B_4L,
            jesd_tl_pkg::MODE_10B_4L: k_val = k_val & ~(jesd_tl_pkg::K_MIN_M23 - 9'h001);
            jesd_tl_pkg::MODE_W4:  k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W4 / jesd_tl_pkg::F_W4);
            jesd_tl_pkg::MODE_W5:  k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W5 / jesd_tl_pkg::F_W5);
            jesd_tl_pkg::MODE_W6:  k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W6 / jesd_tl_pkg::F_W6);
            jesd_tl_pkg::MODE_W7:  k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W7 / jesd_tl_pkg::F_W7);
            jesd_tl_pkg::MODE_W8:  k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W8 / jesd_tl_pkg::F_W8);
            jesd_tl_pkg::MODE_W14: k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W14 / jesd_tl_pkg::F_W14);
            jesd_tl_pkg::MODE_W15: k_val = 9'(jesd_tl_pkg::K_MUL_A * jesd_tl_pkg::K_MUL_B * jesd_tl_pkg::E_W15 / jesd_tl_pkg::F_W15);
            default: k_val = 9'h000;
        endcase
        if (link_mode_select == jesd_tl_pkg::MODE_12B_8L && k_val < jesd_tl_pkg::K_MIN_M0) begin
            k_val = jesd_tl_pkg::K_MIN_M0;
        end else if (link_mode_select == jesd_tl_pkg::MODE_12B_6L && k_val < jesd_tl_pkg::K_MIN_M1) begin
            k_val = jesd_tl_pkg::K_MIN_M1;
        end else if ((link_mode_select == jesd_tl_pkg::MODE_8B_4L || link_mode_select == jesd_tl_pkg::MODE_10B_4L)
                     && k_val < jesd_tl_pkg::K_MIN_M23) begin
            k_val = jesd_tl_pkg::K_MIN_M23;
        end
    end

    // converter count reported as given, equal to lanes in mode 0
    always_ff @(posedge clock) begin
        if (rst) begin
            param_l          <= 4'h0;
            param_m          <= 4'h0;
            param_f          <= 4'h0;
            param_s          <= 4'h0;
            param_n          <= 4'h0;
            param_k          <= 9'h000;
            mode_unsupported <= 1'b0;
            lane_device_id   <= 8'h00;
        end else begin
            param_l          <= l_cnt;
            param_m          <= m_cnt;
            param_f          <= mode_ok ? f_oct : 4'h0;
            param_s          <= s_cnt;
            param_n          <= n_bits;
            param_k          <= (k_val > jesd_tl_pkg::K_MAX) ? jesd_tl_pkg::K_MAX : k_val;
            mode_unsupported <= !mode_ok;
            lane_device_id   <= device_id;
        end
    end

    assign last_octet = (ocnt_reg == f_oct - 4'h1);
    // next frame loads on the last octet of the current one
    assign load       = gathered_reg && mode_ok && (!active_reg || last_octet);
    assign last_use   = (link_mode_select != jesd_tl_pkg::MODE_8B_4L) || half_reg;
    assign fifo_pop   = fifo_valid && data_phase && mode_ok && (!gathered_reg || (load && last_use));
    assign complete   = fifo_pop && (gcnt_reg == words_pf - 3'h1);

    // sample index 2g and 2g+1 from word g; lower index is earlier
    always_ff @(posedge clock) begin
        if (fifo_pop) begin
            for (int c = 0; c < CH; c++) begin
                samp[c][2*gcnt_reg]   <= fifo_data[c*jesd_tl_pkg::PAIR_W +: SW];
                samp[c][2*gcnt_reg+1] <= fifo_data[c*jesd_tl_pkg::PAIR_W+SW +: SW];
            end
        end
    end

    // gathering control; a refill in the load cycle wins over the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            gcnt_reg     <= 3'h0;
            gathered_reg <= 1'b0;
            half_reg     <= 1'b0;
        end else begin
            if (fifo_pop) begin
                gcnt_reg <= complete ? 3'h0 : gcnt_reg + 3'h1;
            end
            if (complete) begin
                gathered_reg <= 1'b1;
            end else if (load && last_use) begin
                gathered_reg <= 1'b0;
            end
            if (link_mode_select != jesd_tl_pkg::MODE_8B_4L) begin
                half_reg <= 1'b0;
            end else if (load) begin
                half_reg <= !half_reg;
            end
        end
    end

    // lane packing, samples right-justified in 12-bit slots
    always_comb begin
        for (int i = 0; i < LN; i++) begin
            frame_map[i] = '0;
        end
        case (link_mode_select)
            jesd_tl_pkg::MODE_12B_8L: begin
                for (int c = 0; c < CH; c++) begin
                    for (int p = 0; p < 2; p++) begin
                        frame_map[2*c+p] = {samp[c][p], samp[c][p+2], samp[c][p+4],
                                            samp[c][p+6], samp[c][p+8], 4'h0};
                    end
                end
            end
            jesd_tl_pkg::MODE_12B_6L: begin
                // pair of channels over three lanes
                for (int g = 0; g < 2; g++) begin
                    frame_map[3*g]   = {samp[2*g][0], samp[2*g][1][11:8], 48'h0};
                    frame_map[3*g+1] = {samp[2*g][1][7:0], samp[2*g+1][0][11:4], 48'h0};
                    frame_map[3*g+2] = {samp[2*g+1][0][3:0], samp[2*g+1][1], 48'h0};
                end
            end
            jesd_tl_pkg::MODE_8B_4L: begin
                for (int c = 0; c < CH; c++) begin
                    frame_map[c] = {samp[c][half_reg][7:0], 56'h0};
                end
            end
            jesd_tl_pkg::MODE_10B_4L: begin
                for (int c = 0; c < CH; c++) begin
                    frame_map[c] = {samp[c][0][9:0], samp[c][1][9:0], samp[c][2][9:0], samp[c][3][9:0], 24'h0};
                end
            end
            default: begin
                for (int i = 0; i < LN; i++) begin
                    frame_map[i] = '0;
                end
            end
        endcase
    end

    // octet counter restarts at 0 for every frame
    always_ff @(posedge clock) begin
        if (rst) begin
            active_reg  <= 1'b0;
            ocnt_reg    <= 4'h0;
            lane_valid  <= 1'b0;
            frame_start <= 1'b0;
        end else if (load) begin
            active_reg  <= 1'b1;
            ocnt_reg    <= 4'h0;
            lane_valid  <= 1'b1;
            frame_start <= 1'b1;
        end else if (active_reg && !last_octet) begin
            ocnt_reg    <= ocnt_reg + 4'h1;
            frame_start <= 1'b0;
        end else begin
            active_reg  <= 1'b0;
            lane_valid  <= 1'b0;
            frame_start <= 1'b0;
        end
    end

    // eight lanes, each with its own serializer
    for (genvar i = 0; i < LN; i++) begin : g_lane
        always_ff @(posedge clock) begin
            if (rst) begin
                shreg[i]              <= '0;
                lane_data[i*OW +: OW] <= 8'h00;
            end else if (load) begin
                lane_data[i*OW +: OW] <= frame_map[i][FW-1 -: OW];
                shreg[i]              <= {frame_map[i][FW-OW-1:0], 8'h00};
            end else if (active_reg && !last_octet) begin
                lane_data[i*OW +: OW] <= shreg[i][FW-1 -: OW];
                shreg[i]              <= {shreg[i][FW-OW-1:0], 8'h00};
            end else begin
                lane_data[i*OW +: OW] <= 8'h00;
            end
        end

        always_ff @(posedge clock) begin
            if (rst) begin
                lane_power_down[i]  <= 1'b1;
                lane_id[i*3 +: 3]   <= 3'h0;
            end else begin
                // lanes at or above the lane count are off
                lane_power_down[i]  <= (4'(i) >= l_cnt);
                lane_id[i*3 +: 3]   <= 3'(i);
            end
        end
    end

endmodule : jesd_transport_lane_mapper

/* bench/jesd_tl_monitor.sv */
`timescale 1ns/1ps
module jesd_tl_monitor (
    // clock and reset
    input wire logic                               clock,
    input wire logic                               rst,
    // configuration and input side
    input wire logic [3:0]                         link_mode_select,
    input wire logic [7:0]                         device_id,
    input wire logic                               sample_ready,
    // lane side
    input wire logic [jesd_tl_pkg::LANES*8-1:0]    lane_data,
    input wire logic                               lane_valid,
    input wire logic                               frame_start,
    input wire logic [jesd_tl_pkg::LANES-1:0]      lane_power_down,
    input wire logic [jesd_tl_pkg::LANES*3-1:0]    lane_id,
    input wire logic [7:0]                         lane_device_id,
    // reported parameters
    input wire logic [3:0]                         param_l,
    input wire logic [3:0]                         param_m,
    input wire logic [3:0]                         param_f,
    input wire logic [8:0]                         param_k
);
    logic [63:0] off_bytes;

    for (genvar i = 0; i < 8; i++) begin : g_off
        assign off_bytes[8*i+:8] = {8{lane_power_down[i]}};
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_lane_id_fixed: assert property (!$past(rst) |-> lane_id == 24'hfac688)
        else $error("lane id field wrong");
    a_devid_copy: assert property (!$past(rst) |-> lane_device_id == $past(device_id))
        else $error("device id not copied");
    a_pd_low_lanes: assert property (!$past(rst) && param_l != 4'h0 |->
        lane_power_down == ~(8'hff >> (4'h8 - param_l)))
        else $error("power down does not match lane count");
    a_unused_zero: assert property ((lane_data & off_bytes) == 64'h0)
        else $error("powered down lane carries data");
    a_m_equals_l: assert property (param_f == 4'h8 |-> param_m == param_l)
        else $error("converter count differs from lane count");
    a_start_valid: assert property (frame_start |-> lane_valid)
        else $error("frame start without valid");
    a_frame_len8: assert property (frame_start && param_f == 4'h8 |=>
        (lane_valid && !frame_start) [*7])
        else $error("eight octet frame broken");
    a_tail_zero: assert property (frame_start && param_f == 4'h8 |->
        ##7 (lane_data & 64'h0f0f0f0f0f0f0f0f) == 64'h0)
        else $error("tail bits not zero");
    a_two_octet: assert property (frame_start && param_f == 4'h2 |=> lane_valid && !frame_start)
        else $error("two octet frame broken");
    a_k_derived: assert property (!$past(rst) && $past(link_mode_select) == 4'h7 |->
        param_k == 9'h100)
        else $error("derived multiframe length wrong");

    c_mode0: cover property (frame_start && param_f == 4'h8);
    c_mode1: cover property (frame_start && param_f == 4'h2);
    c_full: cover property (!sample_ready);
endmodule : jesd_tl_monitor

bind jesd_transport_lane_mapper jesd_tl_monitor u_jesd_tl_monitor (.clock, .rst, .link_mode_select,
    .device_id, .sample_ready, .lane_data, .lane_valid, .frame_start, .lane_power_down, .lane_id,
    .lane_device_id, .param_l, .param_m, .param_f, .param_k);

/* bench/lane_rx_model.sv */
`timescale 1ns/1ps
module lane_rx_model (
    // lane side
    input wire logic        clock,
    input wire logic [63:0] lane_data,
    input wire logic        lane_valid,
    input wire logic        frame_start,
    input wire logic [3:0]  param_f
);
    logic [63:0] acc [8];
    logic [63:0] got [$];
    int          cnt = 0;

    // lane streams kept apart
    // the bench compares each lane stream against its own expected frame word
    always @(posedge clock) begin
        if (lane_valid) begin
            cnt = frame_start ? 0 : cnt + 1;
            for (int i = 0; i < 8; i++) begin
                acc[i] = (frame_start ? 64'h0 : acc[i] << 8) | 64'(lane_data[8*i+:8]);
                if (cnt == int'(param_f) - 1)
                    got.push_back(acc[i]);
            end
        end
    end
endmodule : lane_rx_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                            clock = 1'b0;
    logic                            rst = 1'b1;
    logic [3:0]                      link_mode_select = 4'h0;
    logic [7:0]                      km1 = 8'h00;
    logic [7:0]                      device_id = 8'h00;
    logic                            data_phase = 1'b0;
    logic [jesd_tl_pkg::WORD_W-1:0]  sample_data = '0;
    logic                            sample_valid = 1'b0;
    logic                            sample_ready, lane_valid, frame_start, mode_unsupported;
    logic [63:0]                     lane_data;
    logic [7:0]                      lane_power_down;
    logic [3:0]                      param_l, param_m, param_f, param_s, param_n;
    logic [8:0]                      param_k;
    int n_mismatch = 0, checks_done = 0, seed = 58, md = 0;
    int sq [4][$];
    logic [63:0] exp_q [$];
    int L [4] = '{8, 6, 4, 4}, M [4] = '{8, 4, 4, 4}, F [4] = '{8, 2, 1, 5};
    int S [4] = '{5, 2, 1, 4}, N [4] = '{12, 12, 8, 10}, KS [4] = '{4, 16, 32, 32};

    always #4 clock = ~clock;

    jesd_transport_lane_mapper u_jesd_transport_lane_mapper (.clock, .rst, .link_mode_select,
        .frames_per_multiframe_minus_one(km1), .device_id, .data_phase, .sample_data, .sample_valid,
        .sample_ready, .lane_data, .lane_valid, .frame_start, .lane_power_down, .lane_id(),
        .lane_device_id(), .param_l, .param_m, .param_f, .param_s, .param_n, .param_k,
        .mode_unsupported);
    lane_rx_model u_lane_rx_model (.clock, .lane_data, .lane_valid, .frame_start, .param_f);

    task chk(input logic [63:0] got, input logic [63:0] want);
        checks_done++;
        if (got !== want) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // mode is only changed under reset, so the fifo and framer start clean
    task start(input int m, input logic [7:0] k);
        int kk;
        logic [7:0] pd;
        rst = 1'b1;
        md = m;
        link_mode_select = 4'(m);
        km1 = k;
        device_id = 8'($random(seed));
        data_phase = 1'b0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        for (int c = 0; c < 4; c++) sq[c].delete();
        exp_q.delete();
        u_lane_rx_model.got.delete();
        if (m < 4) begin
            kk = (int'(k) + 1) / KS[m] * KS[m];
            if (kk < KS[m]) kk = KS[m];
            pd = ~(8'hff >> (8 - L[m]));
            chk(param_l, L[m]);
            chk(param_m, M[m]);
            chk(param_f, F[m]);
            chk(param_s, S[m]);
            chk(param_n, N[m]);
            chk(param_k, kk);
            chk(lane_power_down, pd);
            chk(mode_unsupported, 1'b0);
            chk(sample_ready, 1'b1);
            chk(lane_valid, 1'b0);
        end
    endtask : start

    task send(input int nw);
        logic t;
        int r;
        for (int w = 0; w < nw; w++) begin
            for (int c = 0; c < 4; c++) for (int h = 0; h < 2; h++) begin
                r = $random(seed) & ((1 << N[md]) - 1);
                sample_data[24*c+12*h+:12] = 12'(r);
                sq[c].push_back(r);
            end
            sample_valid = 1'b1;
            do begin
                t = sample_ready;
                @(negedge clock);
            end while (!t);
        end
        sample_valid = 1'b0;
    endtask : send

    task frames(input int nf);
        int c, st, b, k;
        logic [63:0] v;
        for (int f = 0; f < nf; f++) for (int l = 0; l < 8; l++) begin
            v = 64'h0;
            if (md == 1 && l < 6) begin
                c = (l / 3) * 2;
                v = {16'h0, 12'(sq[c][2*f]), 12'(sq[c][2*f+1]), 12'(sq[c+1][2*f]), 12'(sq[c+1][2*f+1])};
                v = (v >> (32 - 16 * (l % 3))) & 64'hffff;
            end else if (md != 1 && l < L[md]) begin
                c = (md == 0) ? l / 2 : l;
                st = (md == 0) ? 2 : 1;
                b = f * S[md] * st + ((md == 0) ? l % 2 : 0);
                for (k = 0; k < S[md]; k++) v = (v << N[md]) | 64'(sq[c][b+k*st]);
                if (md == 0) v = v << 4;
            end
            exp_q.push_back(v);
        end
        k = 0;
        while (u_lane_rx_model.got.size() < exp_q.size() && k < 600) begin
            @(negedge clock);
            k++;
        end
        chk(u_lane_rx_model.got.size(), exp_q.size());
        for (int i = 0; i < exp_q.size() && i < u_lane_rx_model.got.size(); i++)
            chk(u_lane_rx_model.got[i], exp_q[i]);
        $display("mode %0d test done", md);
    endtask : frames

    initial begin
        start(0, 8'h05);
        data_phase = 1'b1;
        send(10);
        frames(2);
        // fill the fifo while the link is held out of data phase
        start(1, 8'h28);
        send(32);
        @(negedge clock);
        chk(sample_ready, 1'b0);
        data_phase = 1'b1;
        frames(32);
        start(2, 8'h00);
        data_phase = 1'b1;
        send(6);
        frames(12);
        start(3, 8'hff);
        data_phase = 1'b1;
        send(8);
        frames(4);
        start(4, 8'h00);
        chk(param_k, 9'h080);
        start(7, 8'h00);
        chk(param_k, 9'h100);
        chk(mode_unsupported, 1'b1);
        $display("derived length test done");
        test_done;
    end

    initial begin
        #200000;
        n_mismatch++;
        test_done;
    end
endmodule : tb
